// File: src/balancer_fault_sequencer.sv
// sequencer, lockout gating and fault latch of the balancing controller
// assumes sw_pulse_in is a one-cycle 250 kHz strobe from on-chip logic
`timescale 1ns/1ps
`default_nettype none
module balancer_fault_sequencer
  import balancer_pkg::*;
  #(
    parameter int unsigned HOLD_LEN  = HOLD_CYCLES,
    parameter int unsigned WDOG_LEN  = 2 ** WDOG_BITS
  )
  (
    // clock, reset, enable
    input  wire logic                ref_clk_in,
    input  wire logic                rst_in,
    input  wire logic                clk_en_in,
    // partner handshake pins
    input  wire logic                enable_in,
    input  wire logic                direction_in,
    output logic                     done_out,
    output logic                     direction_echo_out,
    output logic [2:0]               fault_code_out,
    // switching strobe and analog flags
    input  wire logic                sw_pulse_in,
    input  wire sense_flags_s        flags_in,
    input  wire logic [RAMP_W-1:0]   current_setpoint_in,
    // controls toward the analog side
    output logic [RAMP_W-1:0]        current_ref_out,
    output logic                     sense_invert_out,
    output logic                     low_side_supply_lock_out,
    output logic                     high_side_supply_lock_out,
    output logic                     gates_enable_out
  );

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  initial
  begin
    if (HOLD_LEN < 1 || HOLD_LEN > 65535)
      $error("hold length out of range");
    if (WDOG_LEN < 2 || WDOG_LEN > (2 ** 22) - 1)
      $error("watchdog length out of range");
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  localparam int unsigned NSYNC = 9;
  logic [NSYNC-1:0] sync_q;
  logic             en_s;
  logic             dir_s;
  sense_flags_s     fl_s;

  input_sync #(.WIDTH(NSYNC)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({enable_in, direction_in, flags_in}),
    .sync_out   (sync_q)
  );

  assign en_s  = sync_q[8];
  assign dir_s = sync_q[7];
  assign fl_s  = sync_q[6:0];

  // ----------------------------------------
  // state carrier
  // ----------------------------------------
  typedef struct packed {
    seq_state_e        st;
    logic              en_d;
    logic              done;
    logic              echo;
    logic [2:0]        code;
    logic              fault;
    logic [15:0]       hold_cnt;
    logic [RAMP_W-1:0] ramp;
    logic [4:0]        win_cnt;
    logic [2:0]        prim_cnt;
    logic [3:0]        sec_cnt;
    logic [21:0]       wdog_cnt;
    logic              gates;
  } seq_state_s;

  seq_state_s state_reg;
  seq_state_s state_next;

  // priority encoder used for first-fault capture
  function automatic logic [2:0] encode_fault(input logic prim, input logic sec,
                                              input logic therm, input logic wdog,
                                              input logic uv, input logic ov);
    logic [2:0] c;
    c = FLT_NONE;
    if (ov)         c = FLT_OV;
    if (uv)         c = FLT_UV;
    if (wdog)       c = FLT_WDOG;
    if (therm)      c = FLT_THERM;
    if (sec)        c = FLT_SEC;
    if (prim)       c = FLT_PRIM;
    return c;
  endfunction

  logic       en_rise;
  logic       prim_hit;
  logic       sec_hit;
  logic       wdog_hit;
  logic [2:0] new_code;
  logic       supplies_ok;
  logic [RAMP_W-1:0] ramp_dn;

  // ----------------------------------------
  // event detection
  // ----------------------------------------
  assign en_rise     = en_s && !state_reg.en_d;
  assign supplies_ok = fl_s.low_supply_ok && fl_s.high_supply_ok;
  // count includes the event seen in this very cycle
  assign prim_hit = sw_pulse_in && fl_s.prim_limit
                    && (32'(state_reg.prim_cnt) + 1 >= PRIM_LIMIT);
  assign sec_hit  = sw_pulse_in && fl_s.sec_limit
                    && (32'(state_reg.sec_cnt) + 1 >= SEC_LIMIT);
  assign wdog_hit = en_s && (32'(state_reg.wdog_cnt) >= WDOG_LEN);
  assign new_code = encode_fault(prim_hit, sec_hit, fl_s.overtemp, wdog_hit,
                                 fl_s.cell_under, fl_s.cell_over);
  assign ramp_dn  = (state_reg.ramp > RAMP_STEP) ? state_reg.ramp - RAMP_STEP : RAMP_RESET;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    state_next      = state_reg;
    state_next.en_d = en_s;

    case (state_reg.st)
      ST_IDLE:
      begin
        state_next.gates = 1'b0;
        if (en_rise)
        begin
          state_next.st       = ST_HOLD;
          state_next.hold_cnt = '0;
        end
      end
      ST_HOLD:
      begin
        // latches held clear and switching inhibited for the whole pulse
        state_next.done     = 1'b0;
        state_next.echo     = !dir_s;
        state_next.code     = FLT_NONE;
        state_next.fault    = 1'b0;
        state_next.gates    = 1'b0;
        state_next.ramp     = RAMP_RESET;
        state_next.win_cnt  = '0;
        state_next.prim_cnt = '0;
        state_next.sec_cnt  = '0;
        state_next.wdog_cnt = '0;
        state_next.hold_cnt = state_reg.hold_cnt + 16'h0001;
        if (32'(state_reg.hold_cnt) + 1 >= HOLD_LEN)
          state_next.st = en_s ? ST_RUN : ST_STOP;
      end
      ST_RUN:
      begin
        state_next.echo  = !dir_s;
        state_next.gates = supplies_ok;
        if (sw_pulse_in)
        begin
          // soft-start ramp rises one step per switching pulse
          if (state_reg.ramp < current_setpoint_in)
            state_next.ramp = ((current_setpoint_in - state_reg.ramp) > RAMP_STEP)
                              ? state_reg.ramp + RAMP_STEP : current_setpoint_in;
          state_next.wdog_cnt = state_reg.wdog_cnt + 22'h000001;
        end
        if (!en_s)
          state_next.st = ST_STOP;
      end
      ST_STOP:
      begin
        if (sw_pulse_in)
          state_next.ramp = ramp_dn;
        if (state_reg.ramp < STOP_LEVEL)
        begin
          state_next.done  = 1'b1;
          state_next.gates = 1'b0;
          state_next.ramp  = RAMP_RESET;
          state_next.st    = ST_IDLE;
        end
      end
      default:
        state_next.st = ST_IDLE;
    endcase

    // current-limit window, only while converting
    if (state_reg.st == ST_RUN && sw_pulse_in)
    begin
      state_next.win_cnt = state_reg.win_cnt + 5'h01;
      if (32'(state_reg.win_cnt) == WINDOW_PULSES - 1)
      begin
        state_next.prim_cnt = '0;
        state_next.sec_cnt  = '0;
      end
      else
      begin
        if (fl_s.prim_limit && !prim_hit)
          state_next.prim_cnt = state_reg.prim_cnt + 3'h1;
        if (fl_s.sec_limit && !sec_hit)
          state_next.sec_cnt = state_reg.sec_cnt + 4'h1;
      end
    end

    // first fault wins and forces the shutdown path
    if ((state_reg.st == ST_RUN || state_reg.st == ST_STOP) && !state_reg.fault
        && new_code != FLT_NONE)
    begin
      state_next.fault = 1'b1;
      state_next.code  = new_code;
      state_next.gates = 1'b0;
      state_next.ramp  = RAMP_RESET;
      state_next.done  = 1'b1;
      state_next.st    = ST_IDLE;
    end
    if (state_reg.fault)
      state_next.gates = 1'b0;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      state_reg      <= '0;
      state_reg.st   <= ST_IDLE;
      state_reg.done <= 1'b1;
    end
    else if (clk_en_in)
      state_reg <= state_next;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign done_out            = state_reg.done;
  assign direction_echo_out  = state_reg.echo;
  assign fault_code_out      = state_reg.code;
  // reference is the lower of ramp and set-point
  assign current_ref_out     = (state_reg.ramp < current_setpoint_in)
                               ? state_reg.ramp : current_setpoint_in;
  assign sense_invert_out    = dir_s;
  assign low_side_supply_lock_out  = en_s || !state_reg.done;
  assign high_side_supply_lock_out = (en_s || !state_reg.done)
                                     && fl_s.low_supply_ok;
  assign gates_enable_out    = state_reg.gates;

endmodule
`default_nettype wire

// File: src/balancer_pkg.sv
// package of constants and carriers for the balancer fault sequencer
// assumes a 125 MHz ref_clk_in; switching pulses arrive as a strobe input
//
// What this block does
// - on enable rise drive done low, echo inverted direction
// - enable starts a 10 us hold pulse; done, fault cleared, no switching
// - hold pulse clears done and fault latches; start-up waits for its end
// - current reference is the smaller of soft-start ramp and set-point
// - enable fall ramps current down toward zero, about 300 us
// - shutdown completes below 100 mV ramp level; then done goes high
// - done stays latched high until the next enable sequence
// - low-side lockout active while enable high or done low
// - high-side lockout waits for low-side good; both good unlock drivers
// - fault codes: 0 none,1 prim,2 sec,3 thermal,4 watchdog,5 uv,6 ov
// - any fault forces gates off and holds them off latched
// - a fault forces the ramp low path, latching done high
// - encoded fault word latched into the three fault outputs
// - fault code and done stay latched until next start-up
// - current-limit counters reset every 32 switching pulses
// - 4 primary or 8 secondary events in a window raise fault
// - watchdog faults after 2^21 switching pulses with enable high
// - overtemperature flag records thermal fault and shuts down
// - cell voltage outside window flags over or undervoltage fault
// - current sense polarity follows the direction input
package balancer_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned HOLD_NS       = 10_000;
  localparam int unsigned HOLD_CYCLES   = (HOLD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned RAMP_DOWN_US  = 300;
  localparam int unsigned WINDOW_PULSES = 32;
  localparam int unsigned PRIM_LIMIT    = 4;
  localparam int unsigned SEC_LIMIT     = 8;
  localparam int unsigned WDOG_BITS     = 21;

  // ----------------------------------------
  // ramp and thresholds
  // ----------------------------------------
  localparam int unsigned RAMP_W        = 12;
  localparam int unsigned RAMP_FULL_MV  = 2500;
  localparam int unsigned STOP_MV       = 100;
  localparam logic [11:0] STOP_LEVEL    = 12'(STOP_MV * 4095 / RAMP_FULL_MV);
  localparam logic [11:0] RAMP_RESET    = 12'h000;
  // one ramp step per switching pulse: 300 us at 250 kHz is 75 pulses
  localparam int unsigned RAMP_PULSES   = RAMP_DOWN_US / 4;
  localparam logic [11:0] RAMP_STEP     = 12'(4095 / RAMP_PULSES);

  // ----------------------------------------
  // fault codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    FLT_NONE  = 3'h0,
    FLT_PRIM  = 3'h1,
    FLT_SEC   = 3'h2,
    FLT_THERM = 3'h3,
    FLT_WDOG  = 3'h4,
    FLT_UV    = 3'h5,
    FLT_OV    = 3'h6
  } fault_code_e;

  // sequencer states, gray along idle-hold-run-stop
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b11,
    ST_STOP = 2'b10
  } seq_state_e;

  // analog-side flags in one carrier
  typedef struct packed {
    logic prim_limit;
    logic sec_limit;
    logic overtemp;
    logic cell_under;
    logic cell_over;
    logic low_supply_ok;
    logic high_supply_ok;
  } sense_flags_s;

endpackage

// File: src/input_sync.sv
// three-flop synchroniser bank with agreement filter
// assumes inputs are asynchronous levels from pins
`timescale 1ns/1ps
`default_nettype none
module input_sync
  #(parameter int unsigned WIDTH = 1)
  (
    // clock and control
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    // data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
  );

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_s;

  sync_state_s state_reg;
  sync_state_s state_next;

  // accept a change only when second and third stages agree
  always_comb
  begin
    state_next    = state_reg;
    state_next.s1 = async_in;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (state_reg.s2[i] == state_reg.s3[i])
        state_next.q[i] = state_reg.s3[i];
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
      state_reg <= '0;
    else if (clk_en_in)
      state_reg <= state_next;
  end

  assign sync_out = state_reg.q;

endmodule
`default_nettype wire

// File: dv/balancer_seq_chk.sv
// port assertions of the balancer fault sequencer
// assumes a bind onto the top module, hold length handed on
`timescale 1ns/1ps
`default_nettype none
module balancer_seq_chk
  import balancer_pkg::*;
  #(parameter int unsigned HOLD_LEN = 8)
  (
    // clock and reset
    input wire logic        ref_clk_in,
    input wire logic        rst_in,
    // watched ports
    input wire logic        enable_in,
    input wire logic        done_out,
    input wire logic        direction_echo_out,
    input wire logic [2:0]  fault_code_out,
    input wire logic [11:0] current_setpoint_in,
    input wire logic [11:0] current_ref_out,
    input wire logic        sense_invert_out,
    input wire logic        low_side_supply_lock_out,
    input wire logic        gates_enable_out
  );
  // ------
  // helper
  // ------
  // cycles since done fell; saturates so long runs never wrap
  logic [31:0] since_reg;
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in || $fell(done_out))
      since_reg <= 32'h0;
    else if (since_reg != 32'hffffffff)
      since_reg <= since_reg + 32'h1;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ----------
  // assertions
  // ----------
  lock_low_a: assert property (!done_out |-> low_side_supply_lock_out)
    else $error("low lock off while busy");
  hold_gate_a: assert property (
    gates_enable_out |-> since_reg >= HOLD_LEN - 2) else $error("gates on in hold");
  ref_min_a: assert property (current_ref_out <= current_setpoint_in)
    else $error("reference above set-point");
  done_keep_a: assert property (
    (done_out && !enable_in) [*6] |=> done_out) else $error("done dropped alone");
  fault_gate_a: assert property (fault_code_out != 3'h0 |-> !gates_enable_out)
    else $error("gates on with fault");
  fault_done_a: assert property (
    $changed(fault_code_out) && fault_code_out != 3'h0 |-> done_out)
    else $error("fault without done");
  first_fault_a: assert property (
    fault_code_out != 3'h0 && $past(fault_code_out) != 3'h0 |-> $stable(fault_code_out))
    else $error("later fault overwrote code");
  echo_dir_a: assert property (
    !done_out && !$past(done_out) && $stable(sense_invert_out)
      |-> direction_echo_out != sense_invert_out) else $error("echo not inverse");
endmodule
bind balancer_fault_sequencer balancer_seq_chk #(.HOLD_LEN(HOLD_LEN)) u_balancer_seq_chk (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .enable_in(enable_in), .done_out(done_out),
  .direction_echo_out(direction_echo_out), .fault_code_out(fault_code_out),
  .current_setpoint_in(current_setpoint_in), .current_ref_out(current_ref_out),
  .sense_invert_out(sense_invert_out), .low_side_supply_lock_out(low_side_supply_lock_out),
  .gates_enable_out(gates_enable_out));
`default_nettype wire

// File: dv/balancer_host_model.sv
// model of the driver chip on the far side of the enable pins
// assumes go_in from the bench; pins move 1 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module balancer_host_model
  import balancer_pkg::*;
  #(parameter int unsigned RUN_LIM = 0)
  (
    // bench commands
    input  wire logic       ref_clk_in,
    input  wire logic       go_in,
    input  wire logic       dir_cmd_in,
    // device pins
    input  wire logic       done_in,
    input  wire logic [2:0] fault_code_in,
    output logic            enable_out,
    output logic            direction_out,
    output logic [2:0]      fault_seen_out
  );
  logic ran = 1'b0;
  int   run_cnt = 0;
  initial
  begin
    enable_out = 1'b0;
    fault_seen_out = 3'h0;
  end
  assign direction_out = dir_cmd_in;
  // one start per go; done seen low then high ends it, no restart
  always @(posedge ref_clk_in)
  begin
    run_cnt <= enable_out ? run_cnt + 1 : 0;
    if (!go_in)
    begin
      enable_out <= #1 1'b0;
      ran <= 1'b0;
    end
    else if (!enable_out && !ran)
      enable_out <= #1 1'b1;
    else if (enable_out && !done_in)
      ran <= 1'b1;
    else if (enable_out && ran)
    begin
      fault_seen_out <= #1 fault_code_in;
      enable_out <= #1 1'b0;
    end
    // a zero limit leaves long runs to the bench
    if (RUN_LIM != 0 && run_cnt >= RUN_LIM)
      enable_out <= #1 1'b0;
  end
endmodule
`default_nettype wire

// File: dv/tb_balancer_fault_sequencer.sv
// self-checking bench of the balancer fault sequencer
// assumes the host model drives enable; flags are held levels
`timescale 1ns/1ps
`default_nettype none
module tb_balancer_fault_sequencer;
  import balancer_pkg::*;
  // short hold and watchdog keep the run brief
  localparam int unsigned HOLD = 8;
  localparam int unsigned WDOG = 128;
  typedef struct packed {
    logic [2:0]  kind;
    logic        dir;
    logic [11:0] sp;
    logic [2:0]  code;
  } row_s;
  logic         ref_clk_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         sw_pulse_in = 1'b0;
  logic         go = 1'b0;
  logic         dir_cmd = 1'b0;
  logic         enable_in, direction_in, done_out, echo_out, sense_inv, lock_lo, lock_hi;
  logic         gates;
  logic [2:0]   code_out, seen_code;
  logic [11:0]  setpoint = 12'h200;
  logic [11:0]  ref_out;
  sense_flags_s flags = 7'h03;
  int           fails = 0;
  int           checks_done = 0;
  int           div = 0;
  row_s         rows [9] = '{
    '{3'h0, 1'b1, 12'h200, FLT_NONE}, '{3'h0, 1'b0, 12'h300, FLT_NONE},
    '{3'h1, 1'b0, 12'h200, FLT_PRIM}, '{3'h2, 1'b1, 12'h200, FLT_SEC},
    '{3'h3, 1'b1, 12'h200, FLT_THERM}, '{3'h4, 1'b0, 12'h200, FLT_WDOG},
    '{3'h5, 1'b0, 12'h200, FLT_UV}, '{3'h6, 1'b1, 12'h200, FLT_OV},
    '{3'h7, 1'b1, 12'h200, FLT_THERM}};
  always #4 ref_clk_in = ~ref_clk_in;
  // strobe every fourth cycle; it never pauses, since events count only on strobes
  always @(posedge ref_clk_in)
  begin
    div <= (div + 1) % 4;
    sw_pulse_in <= #1 div == 3;
  end
  balancer_fault_sequencer #(.HOLD_LEN(HOLD), .WDOG_LEN(WDOG)) u_balancer_fault_sequencer (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .clk_en_in(1'b1), .enable_in(enable_in),
    .direction_in(direction_in), .done_out(done_out), .direction_echo_out(echo_out),
    .fault_code_out(code_out), .sw_pulse_in(sw_pulse_in), .flags_in(flags),
    .current_setpoint_in(setpoint), .current_ref_out(ref_out), .sense_invert_out(sense_inv),
    .low_side_supply_lock_out(lock_lo), .high_side_supply_lock_out(lock_hi),
    .gates_enable_out(gates));
  balancer_host_model u_balancer_host_model (
    .ref_clk_in(ref_clk_in), .go_in(go), .dir_cmd_in(dir_cmd), .done_in(done_out),
    .fault_code_in(code_out), .enable_out(enable_in), .direction_out(direction_in),
    .fault_seen_out(seen_code));
  task automatic check(input string name, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // bounded wait on done (sel 0) or gates (sel 1)
  task automatic wait_on(input int sel, input logic val, input int lim);
    for (int n = 0; n < lim && ((sel == 0) ? done_out : gates) !== val; n++)
      cyc(1);
    check(sel == 0 ? "done" : "gates", val, (sel == 0) ? done_out : gates);
  endtask
  // each pulse of the flag spans exactly one strobe, so one event per pulse
  task automatic burst(input int bit_no, input int n);
    repeat (n)
    begin
      flags[bit_no] = 1'b1;
      cyc(4);
      flags[bit_no] = 1'b0;
      cyc(4);
    end
  endtask
  task automatic start_run(input logic dir, input logic [11:0] sp);
    dir_cmd = dir;
    setpoint = sp;
    cyc(6);
    check("low lock idle", 1'b0, lock_lo);
    go = 1'b1;
    wait_on(0, 1'b0, 20);
    cyc(3);
    check("code cleared", 3'h0, code_out);
    check("echo", !dir, echo_out);
    check("sense", dir, sense_inv);
    wait_on(1, 1'b1, HOLD + 20);
  endtask
  task automatic reset_check;
    check("rst done", 1'b1, done_out);
    check("rst code", 3'h0, code_out);
    check("rst gates", 1'b0, gates);
    check("rst ref", 12'h0, ref_out);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10000) @(posedge ref_clk_in);
    fails++;
    report_and_stop();
  end
  initial
  begin
    cyc(20);
    reset_check();
    rst_in = 1'b0;
    cyc(10);
    foreach (rows[i])
    begin
      start_run(rows[i].dir, rows[i].sp);
      case (rows[i].kind)
        3'h1: burst(6, PRIM_LIMIT);
        3'h2: burst(5, SEC_LIMIT);
        3'h3: flags.overtemp = 1'b1;
        3'h5: flags.cell_under = 1'b1;
        3'h6: flags.cell_over = 1'b1;
        3'h7: flags[4:2] = 3'b101;
        default: ;
      endcase
      if (rows[i].kind == 3'h4)
      begin
        cyc(WDOG * 4 - 40);
        check("early timeout", 1'b0, done_out);
      end
      if (rows[i].kind == 3'h0)
      begin
        cyc(120);
        check("ref", rows[i].sp, ref_out);
        go = 1'b0;
        cyc(16);
        check("ramp down", 1'b0, done_out);
      end
      wait_on(0, 1'b1, WDOG * 4 + 400);
      check("code", rows[i].code, code_out);
      check("gates off", 1'b0, gates);
      check("stop", 1'b1, ref_out < STOP_LEVEL || rows[i].kind != 3'h0);
      cyc(12);
      if (rows[i].kind != 3'h0)
        check("read", rows[i].code, seen_code);
      flags = 7'h03;
      go = 1'b0;
      cyc(12);
    end
    // below the limits in one window, then a fresh window
    start_run(1'b1, 12'h200);
    burst(6, PRIM_LIMIT - 1);
    burst(5, SEC_LIMIT - 1);
    cyc(4 * WINDOW_PULSES + 8);
    burst(6, PRIM_LIMIT - 1);
    check("window", 3'h0, code_out);
    flags.overtemp = 1'b1;
    wait_on(0, 1'b1, 20);
    flags.cell_over = 1'b1;
    cyc(10);
    check("first", FLT_THERM, code_out);
    flags = 7'h03;
    go = 1'b0;
    cyc(12);
    // supply loss in mid-run, then reset in mid-run
    start_run(1'b0, 12'h200);
    check("low lock", 1'b1, lock_lo);
    flags.low_supply_ok = 1'b0;
    cyc(8);
    check("high lock", 1'b0, lock_hi);
    check("no supply", 1'b0, gates);
    flags = 7'h03;
    rst_in = 1'b1;
    cyc(2);
    reset_check();
    rst_in = 1'b0;
    go = 1'b0;
    cyc(10);
    report_and_stop();
  end
endmodule
`default_nettype wire
